// ===== pkg/idf_pkg.sv
// Package: field layouts, codes and structs for the instruction field decoder
package idf_pkg;

  localparam int WORD_W = 16;
  localparam int REG_W = 4;

  // Field positions of core formats
  localparam int RN_HI = 11;
  localparam int RN_LO = 8;
  localparam int RM_HI = 7;
  localparam int RM_LO = 4;

  // Transfer class prefixes in bits 15:10
  localparam logic [5:0] DOUBLE_PREFIX = 6'h3C;
  localparam logic [5:0] SINGLE_PREFIX = 6'h3D;

  // Pointer registers for transfers
  localparam logic [3:0] PTR_R2 = 4'h2;
  localparam logic [3:0] PTR_R3 = 4'h3;
  localparam logic [3:0] PTR_R4 = 4'h4;
  localparam logic [3:0] PTR_R5 = 4'h5;
  localparam logic [3:0] PTR_R6 = 4'h6;
  localparam logic [3:0] PTR_R7 = 4'h7;
  localparam logic [3:0] INDEX_XS = 4'h8;
  localparam logic [3:0] INDEX_Y = 4'h9;

  // Single-transfer data register codes
  localparam logic [3:0] DS_A1 = 4'h5;
  localparam logic [3:0] DS_A0 = 4'h7;
  localparam logic [3:0] DS_X0 = 4'h8;
  localparam logic [3:0] DS_Y1 = 4'hB;
  localparam logic [3:0] DS_M0 = 4'hC;
  localparam logic [3:0] DS_A1G = 4'hD;
  localparam logic [3:0] DS_M1 = 4'hE;
  localparam logic [3:0] DS_A0G = 4'hF;

  // Address step sizes in bytes
  localparam logic [2:0] STEP_WORD = 3'h2;
  localparam logic [2:0] STEP_LONG = 3'h4;

  // Pipeline latency from fetch to registered fields
  localparam int DECODE_LATENCY = 1;

  typedef enum logic [1:0] {
    DX_NOP,
    DX_INDIRECT,
    DX_INC,
    DX_INDEX
  } idf_dmode_e;

  typedef enum logic [1:0] {
    SX_PREDEC,
    SX_INDIRECT,
    SX_POSTINC,
    SX_INDEX
  } idf_smode_e;

  typedef struct packed {
    logic [3:0] rn;
    logic [3:0] rm;
    logic [3:0] disp4;
    logic [7:0] imm8;
    logic [11:0] disp12;
  } idf_core_s;

  typedef struct packed {
    logic valid;
    logic [3:0] x_pointer;
    logic [3:0] y_pointer;
    logic x_data_sel;
    logic y_data_sel;
    logic x_store;
    logic y_store;
    idf_dmode_e x_mode;
    idf_dmode_e y_mode;
  } idf_double_s;

  typedef struct packed {
    logic valid;
    logic long_size;
    logic store;
    logic [3:0] single_transfer_pointer;
    logic [3:0] single_transfer_data_reg;
    idf_smode_e mode;
    logic [2:0] step;
    logic illegal;
  } idf_single_s;

endpackage : idf_pkg

// ===== verilog/idf_dsp_xfer.sv
// DSP double and single data transfer field extraction
`timescale 1ns/100ps
module idf_dsp_xfer
  import idf_pkg::*;
(
  input wire logic [15:0] word,
  output idf_double_s dbl,
  output idf_single_s sgl
);

  wire is_double;
  wire is_single;
  wire [3:0] ds_code;
  wire ds_legal;
  logic [3:0] s_ptr;

  assign is_double = (word[15:10] == DOUBLE_PREFIX); // RQ9
  assign is_single = (word[15:10] == SINGLE_PREFIX); // RQ12
  assign ds_code = word[7:4];
  // Reserved codes 0-4 and 6 are refused
  assign ds_legal = (ds_code == DS_A1) || (ds_code >= DS_A0); // RQ13

  always_comb begin
    case (word[9:8])
      2'h0: s_ptr = PTR_R4;
      2'h1: s_ptr = PTR_R5;
      2'h2: s_ptr = PTR_R2;
      default: s_ptr = PTR_R3;
    endcase
  end

  assign dbl.valid = is_double; // RQ8
  assign dbl.x_pointer = word[9] ? PTR_R5 : PTR_R4; // RQ9
  assign dbl.y_pointer = word[8] ? PTR_R7 : PTR_R6; // RQ9
  assign dbl.x_data_sel = word[7]; // RQ10
  assign dbl.y_data_sel = word[6]; // RQ10
  assign dbl.x_store = word[5]; // RQ11
  assign dbl.y_store = word[4]; // RQ11
  assign dbl.x_mode = idf_dmode_e'(word[3:2]); // RQ11
  assign dbl.y_mode = idf_dmode_e'(word[1:0]); // RQ11

  assign sgl.valid = is_single; // RQ8
  assign sgl.long_size = word[1];
  assign sgl.store = word[0];
  assign sgl.single_transfer_pointer = s_ptr; // RQ12
  assign sgl.single_transfer_data_reg = ds_code; // RQ13
  assign sgl.mode = idf_smode_e'(word[3:2]); // RQ14
  assign sgl.step = word[1] ? STEP_LONG : STEP_WORD; // RQ14
  assign sgl.illegal = is_single && !ds_legal; // RQ15

endmodule : idf_dsp_xfer

// ===== verilog/idf_decoder.sv
// Instruction operand field decoder for core and DSP transfer words
//
// Behaviour
// RQ1 - Core words are 16 bits, 15..0; 4-bit fields name registers
// RQ2 - Immediate and displacement fields extracted separately from opcode bits
// RQ3 - Field meaning (addressing mode) is chosen by the opcode downstream
// RQ4 - Rn at 11:8, Rm at 7:4, 4-bit displacement at 3:0
// RQ5 - 8-bit disp/imm at 7:0, 12-bit disp at 11:0, Rn with 8-bit
// RQ6 - Far branch adds register 11:8 to PC, not a pointer
// RQ7 - Multiply-accumulate: both fields post-increment pointers, result to MAC
// RQ8 - DSP transfers recognised as 16-bit double or single forms
// RQ9 - Double: prefix 111100, bit 9 picks R4/R5, bit 8 R6/R7
// RQ10 - Double: bits 7/6 select input or accumulator data register
// RQ11 - Double: bits 5/4 direction, 3:2 and 1:0 addressing mode
// RQ12 - Single: prefix 111101, bits 9:8 pick R4, R5, R2, R3
// RQ13 - Single: bits 7:4 pick DSP register; other codes reserved
// RQ14 - Single: bits 3:2 addressing; step 2 for word, 4 long
// RQ15 - Fields combinational from fetch, registered; reserved codes flagged
`timescale 1ns/100ps
module idf_decoder
  import idf_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_word,
  input wire logic is_far_branch,
  input wire logic is_mac,
  input wire logic [31:0] pc,
  input wire logic [31:0] rn_value,
  output idf_core_s core_f,
  output idf_double_s double_f,
  output idf_single_s single_f,
  output logic [31:0] far_target,
  output logic rn_is_pointer,
  output logic rm_is_pointer,
  output logic rn_post_inc,
  output logic rm_post_inc,
  output logic dest_is_mac,
  output logic illegal,
  output logic out_valid
);

  // ----------------------------------------------------------------
  // Combinational extraction
  // ----------------------------------------------------------------
  idf_core_s core_d;
  idf_double_s dbl_d;
  idf_single_s sgl_d;

  assign core_d.rn = fetch_word[RN_HI:RN_LO]; // RQ1 RQ4
  assign core_d.rm = fetch_word[RM_HI:RM_LO]; // RQ4
  assign core_d.disp4 = fetch_word[3:0]; // RQ2 RQ4
  assign core_d.imm8 = fetch_word[7:0]; // RQ5
  assign core_d.disp12 = fetch_word[11:0]; // RQ5

  idf_dsp_xfer u_xfer (
    .word(fetch_word),
    .dbl(dbl_d),
    .sgl(sgl_d)
  );

  // Opcode-driven interpretation happens in execute; only role hints here
  wire mac_d = is_mac && !sgl_d.valid && !dbl_d.valid; // RQ3 RQ7
  wire far_d = is_far_branch && !sgl_d.valid && !dbl_d.valid; // RQ6

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  idf_core_s core_q;
  idf_double_s dbl_q;
  idf_single_s sgl_q;
  logic mac_q;
  logic far_q;
  logic illegal_q;
  logic valid_q;
  logic [31:0] target_q;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      core_q <= '0;
      dbl_q <= '0;
      sgl_q <= '0;
      mac_q <= 1'b0;
      far_q <= 1'b0;
      illegal_q <= 1'b0;
      valid_q <= 1'b0;
      target_q <= '0;
    end else begin
      core_q <= core_d; // RQ15
      dbl_q <= fetch_valid ? dbl_d : '0;
      sgl_q <= fetch_valid ? sgl_d : '0;
      mac_q <= fetch_valid && mac_d;
      far_q <= fetch_valid && far_d;
      illegal_q <= fetch_valid && sgl_d.illegal; // RQ15
      valid_q <= fetch_valid;
      target_q <= pc + rn_value; // RQ6
    end
  end

  assign core_f = core_q;
  assign double_f = dbl_q;
  assign single_f = sgl_q;
  assign far_target = target_q;
  // Far branch register is never a pointer, even if both hints are raised; rn_post_inc still follows mac_q
  assign rn_is_pointer = mac_q && !far_q; // RQ6 RQ7
  assign rm_is_pointer = mac_q; // RQ7
  assign rn_post_inc = mac_q; // RQ7
  assign rm_post_inc = mac_q; // RQ7
  assign dest_is_mac = mac_q; // RQ7
  assign illegal = illegal_q;
  assign out_valid = valid_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_rn_field;
    @(posedge core_clk) disable iff (reset)
      1'b1 |=> core_f.rn == $past(fetch_word[11:8]);
  endproperty
  a_rn_field: assert property (p_rn_field) // RQ4
    else $error("rn field wrong");

  property p_fields;
    @(posedge core_clk) disable iff (reset)
      1'b1 |=> core_f.rm == $past(fetch_word[7:4])
        && core_f.disp4 == $past(fetch_word[3:0])
        && core_f.disp12 == $past(fetch_word[11:0]);
  endproperty
  a_fields: assert property (p_fields) // RQ5
    else $error("displacement fields wrong");

  property p_far;
    @(posedge core_clk) disable iff (reset)
      1'b1 |=> far_target == $past(pc) + $past(rn_value);
  endproperty
  a_far: assert property (p_far) // RQ6
    else $error("far target wrong");

  property p_mac;
    @(posedge core_clk) disable iff (reset)
      fetch_valid && is_mac && fetch_word[15:11] != 5'h1E
        |=> dest_is_mac && rn_post_inc && rm_post_inc;
  endproperty
  a_mac: assert property (p_mac) // RQ7
    else $error("mac roles wrong");

  property p_dbl_ptr;
    @(posedge core_clk) disable iff (reset)
      fetch_valid && fetch_word[15:10] == 6'h3C |=> double_f.valid
        && double_f.x_pointer == ($past(fetch_word[9]) ? 4'h5 : 4'h4)
        && double_f.y_pointer == ($past(fetch_word[8]) ? 4'h7 : 4'h6);
  endproperty
  a_dbl_ptr: assert property (p_dbl_ptr) // RQ9
    else $error("double pointer wrong");

  property p_dbl_mode;
    @(posedge core_clk) disable iff (reset)
      fetch_valid && fetch_word[15:10] == 6'h3C |=>
        double_f.x_store == $past(fetch_word[5])
        && double_f.y_mode == $past(fetch_word[1:0])
        && double_f.x_data_sel == $past(fetch_word[7]);
  endproperty
  a_dbl_mode: assert property (p_dbl_mode) // RQ11
    else $error("double mode wrong");

  property p_sgl_ptr;
    @(posedge core_clk) disable iff (reset)
      fetch_valid && fetch_word[15:8] == 8'hF6 |=>
        single_f.valid && single_f.single_transfer_pointer == 4'h2;
  endproperty
  a_sgl_ptr: assert property (p_sgl_ptr) // RQ12
    else $error("single pointer wrong");

  property p_sgl_illegal;
    @(posedge core_clk) disable iff (reset)
      fetch_valid && fetch_word[15:10] == 6'h3D
        && fetch_word[7:4] == 4'h6 |=> illegal && single_f.illegal;
  endproperty
  a_sgl_illegal: assert property (p_sgl_illegal) // RQ15
    else $error("reserved code not flagged");

  property p_step;
    @(posedge core_clk) disable iff (reset)
      fetch_valid && fetch_word[15:10] == 6'h3D |=>
        single_f.step == ($past(fetch_word[1]) ? 3'h4 : 3'h2);
  endproperty
  a_step: assert property (p_step) // RQ14
    else $error("step size wrong");

  property p_far_ptr;
    @(posedge core_clk) disable iff (reset)
      fetch_valid && is_far_branch |=> !rn_is_pointer;
  endproperty
  a_far_ptr: assert property (p_far_ptr) // RQ6
    else $error("far branch register marked as pointer");

  property p_dbl_data;
    @(posedge core_clk) disable iff (reset)
      fetch_valid && fetch_word[15:10] == 6'h3C |=>
        double_f.y_data_sel == $past(fetch_word[6])
        && double_f.y_store == $past(fetch_word[4])
        && double_f.x_mode == $past(fetch_word[3:2]);
  endproperty
  a_dbl_data: assert property (p_dbl_data) // RQ10
    else $error("double data select wrong");

  property p_sgl_fields;
    @(posedge core_clk) disable iff (reset)
      fetch_valid && fetch_word[15:10] == 6'h3D |=>
        single_f.single_transfer_data_reg == $past(fetch_word[7:4])
        && single_f.mode == $past(fetch_word[3:2])
        && single_f.store == $past(fetch_word[0])
        && single_f.long_size == $past(fetch_word[1]);
  endproperty
  a_sgl_fields: assert property (p_sgl_fields) // RQ13
    else $error("single fields wrong");

  property p_idle;
    @(posedge core_clk) disable iff (reset)
      !fetch_valid |=> !out_valid && !double_f.valid && !single_f.valid
        && !illegal && !dest_is_mac;
  endproperty
  a_idle: assert property (p_idle) // RQ15
    else $error("outputs active without fetch");

  c_double: cover property (@(posedge core_clk) double_f.valid);
  c_single: cover property (@(posedge core_clk) single_f.valid);
  c_illegal: cover property (@(posedge core_clk) illegal);
  c_mac: cover property (@(posedge core_clk) dest_is_mac);
  c_idle: cover property (@(posedge core_clk) out_valid ##1 !out_valid);

endmodule : idf_decoder

// ===== test/idf_fetch_model.sv
// Fetch-stage model that hands instruction words to the decoder
`timescale 1ns/100ps
module idf_fetch_model
  import idf_pkg::*;
(
  input wire logic core_clk,
  input wire logic next_valid,
  input wire logic [15:0] next_word,
  output logic fetch_valid,
  output logic [15:0] fetch_word
);
  logic [15:0] last_q;
  // Idle bus shows inverted last word, so stale data never matches
  assign fetch_valid = next_valid;
  assign fetch_word = next_valid ? next_word : ~last_q;
  always_ff @(posedge core_clk) begin
    if (next_valid) begin
      last_q <= next_word;
    end
  end
endmodule : idf_fetch_model

// ===== test/idf_decoder_bench.sv
// Self-checking bench for the instruction field decoder
`timescale 1ns/100ps
module idf_decoder_bench;
  import idf_pkg::*;
  logic core_clk, reset, nxt_valid, is_far_branch, is_mac, fetch_valid;
  logic [15:0] nxt_word, fetch_word;
  logic [31:0] pc, rn_value, far_target;
  idf_core_s core_f;
  idf_double_s double_f, dx;
  idf_single_s single_f, sx;
  logic rn_is_pointer, rm_is_pointer, rn_post_inc, rm_post_inc;
  logic dest_is_mac, illegal, out_valid;
  logic [9:0] j;
  int num_errors = 0;
  int n_tests = 0;

  idf_fetch_model i_fetch(.core_clk(core_clk), .next_valid(nxt_valid),
    .next_word(nxt_word), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word));
  idf_decoder i_dut(.core_clk(core_clk), .reset(reset),
    .fetch_valid(fetch_valid), .fetch_word(fetch_word),
    .is_far_branch(is_far_branch), .is_mac(is_mac), .pc(pc),
    .rn_value(rn_value), .core_f(core_f), .double_f(double_f),
    .single_f(single_f), .far_target(far_target),
    .rn_is_pointer(rn_is_pointer), .rm_is_pointer(rm_is_pointer),
    .rn_post_inc(rn_post_inc), .rm_post_inc(rm_post_inc),
    .dest_is_mac(dest_is_mac), .illegal(illegal), .out_valid(out_valid));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  // Drive on falling edge, look just after the sampling edge
  task apply(logic [15:0] w, logic v, logic fb, logic mc);
    @(negedge core_clk);
    nxt_word = w;
    nxt_valid = v;
    is_far_branch = fb;
    is_mac = mc;
    @(posedge core_clk);
    #1;
  endtask : apply

  task final_report;
    $display("Checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_core;
    pc = 32'h1000_0000;
    rn_value = 32'h0000_0124;
    apply(16'hA5C3, 1'b1, 1'b1, 1'b0);
    chk("core_regs", {core_f.rn, core_f.rm, core_f.disp4}, 12'h5C3);
    chk("core_imm", {core_f.imm8, core_f.disp12}, 20'hC35C3);
    chk("far_target", far_target, 32'h1000_0124);
    chk("far_ptr", rn_is_pointer, 1'b0);
    chk("out_valid", out_valid, 1'b1);
    apply(16'h0A23, 1'b1, 1'b1, 1'b1);
    chk("far_mac_ptr", rn_is_pointer, 1'b0);
    $display("done core");
  endtask : t_core

  task t_mac;
    apply(16'h4A6F, 1'b1, 1'b0, 1'b1);
    chk("mac_roles", {rn_is_pointer, rm_is_pointer, rn_post_inc,
      rm_post_inc, dest_is_mac}, 5'h1F);
    apply(16'h4A6F, 1'b1, 1'b0, 1'b0);
    chk("plain_roles", {rn_is_pointer, rm_is_pointer, dest_is_mac},
      3'h0);
    apply(16'h4A6F, 1'b0, 1'b0, 1'b1);
    chk("idle_mac", dest_is_mac, 1'b0);
    $display("done mac");
  endtask : t_mac

  task t_double;
    for (int i = 0; i < 1024; i++) begin
      j = i[9:0];
      apply({DOUBLE_PREFIX, j}, 1'b1, 1'b0, 1'b0);
      dx.valid = 1'b1;
      dx.x_pointer = j[9] ? PTR_R5 : PTR_R4;
      dx.y_pointer = j[8] ? PTR_R7 : PTR_R6;
      dx.x_data_sel = j[7];
      dx.y_data_sel = j[6];
      dx.x_store = j[5];
      dx.y_store = j[4];
      dx.x_mode = idf_dmode_e'(j[3:2]);
      dx.y_mode = idf_dmode_e'(j[1:0]);
      chk("double", double_f, dx);
      chk("dbl_other", {single_f.valid, illegal}, 2'h0);
    end
    $display("done double");
  endtask : t_double

  task t_single;
    for (int i = 0; i < 1024; i++) begin
      j = i[9:0];
      apply({SINGLE_PREFIX, j}, 1'b1, 1'b0, 1'b0);
      sx.valid = 1'b1;
      sx.long_size = j[1];
      sx.store = j[0];
      sx.single_transfer_pointer = j[9] ? (j[8] ? PTR_R3 : PTR_R2)
        : (j[8] ? PTR_R5 : PTR_R4);
      sx.single_transfer_data_reg = j[7:4];
      sx.mode = idf_smode_e'(j[3:2]);
      sx.step = j[1] ? STEP_LONG : STEP_WORD;
      sx.illegal = (j[7:4] < 4'h5) || (j[7:4] == 4'h6);
      chk("single", single_f, sx);
      chk("sgl_illegal", illegal, sx.illegal);
      chk("sgl_dbl", double_f.valid, 1'b0);
    end
    $display("done single");
  endtask : t_single

  task t_other;
    apply(16'hF800, 1'b1, 1'b0, 1'b0);
    chk("parallel", {double_f.valid, single_f.valid}, 2'h0);
    apply(16'hF0FF, 1'b0, 1'b0, 1'b0);
    chk("idle_dbl", double_f, 17'h0);
    chk("idle_valid", out_valid, 1'b0);
    $display("done other");
  endtask : t_other

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    reset = 1'b1;
    nxt_word = 16'hF0FF;
    nxt_valid = 1'b1;
    is_far_branch = 1'b0;
    is_mac = 1'b0;
    pc = 32'h0;
    rn_value = 32'h0;
    repeat (5) @(posedge core_clk);
    #1;
    chk("reset_dbl", {double_f, out_valid}, 18'h0);
    @(negedge core_clk);
    reset = 1'b0;
    t_core;
    t_mac;
    t_double;
    t_single;
    t_other;
    final_report;
  end

  // Tests need about 2100 cycles
  initial begin
    repeat (6000) @(posedge core_clk);
    num_errors++;
    final_report;
  end
endmodule : idf_decoder_bench
